// File: rtl/tws_slave.sv
/*
 * Two-wire serial register slave with 256 sixteen-bit registers,
 * auto-incrementing index and byte-lane access at index F0.
 * Assumes an external pull-up on the data line and a master that
 * runs its serial clock far slower than the master clock.
 */
module tws_slave (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic serial_clock_line,
   input wire logic serial_data_line_in,
   output logic serial_data_line_out,
   output logic serial_data_line_oe,
   input wire logic bus_id_strap_hi,
   input wire logic bus_id_strap_lo
);

   ////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      tws_pkg::tws_state_e st;
      logic scl_prev;
      logic sda_prev;
      logic [7:0] shift;
      logic [3:0] cnt;
      logic drive_low;
      logic rd;
      logic need_idx;
      logic half;
      logic nack;
      logic [7:0] idx;
      logic [7:0] hi_byte;
      logic [7:0] hi_idx;
   } tws_slave_s;

   tws_slave_s r_reg;
   tws_slave_s r_next;

   logic [tws_pkg::REG_WIDTH-1:0] regs_reg [tws_pkg::REG_COUNT];
   logic wr_en;
   logic [7:0] wr_idx;
   logic [15:0] wr_data;

   logic [tws_pkg::SYNC_WIDTH-1:0] pins;
   logic scl;
   logic sda;
   logic [7:0] my_id;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [7:0] tx_byte;
   logic tx_first;

   ////////////////////////////////////////////////////////////////////
   // Pin sampling.

   // The strap and serial line levels pass the two-flop bank first; rst_n and ce do not.
   tws_sync u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .async_in({bus_id_strap_hi, bus_id_strap_lo,
                 serial_clock_line, serial_data_line_in}),
      .sync_out(pins)
   );

   assign scl = pins[1];
   assign sda = pins[0];

   // Strap pins choose the write-direction identity.
   always_comb begin
      case ({pins[3], pins[2]})
         2'b00: my_id = tws_pkg::ID_STRAP_00;
         2'b01: my_id = tws_pkg::ID_STRAP_01;
         2'b10: my_id = tws_pkg::ID_STRAP_10;
         default: my_id = tws_pkg::ID_STRAP_11;
      endcase
   end

   // Clock edges and bus conditions from the synchronised lines.
   assign scl_rise = scl && !r_reg.scl_prev;
   assign scl_fall = !scl && r_reg.scl_prev;
   assign start_seen = scl && r_reg.scl_prev && r_reg.sda_prev && !sda;
   assign stop_seen = scl && r_reg.scl_prev && !r_reg.sda_prev && sda;

   ////////////////////////////////////////////////////////////////////
   // Transmit byte selection.

   // The byte-lane index returns the lower half of the last target.
   always_comb begin
      tx_first = 1'b0;
      if (r_reg.idx == tws_pkg::BYTE_LANE_IDX) begin
         tx_byte = regs_reg[r_reg.hi_idx][7:0];
      end else if (r_reg.half) begin
         tx_byte = regs_reg[r_reg.idx][7:0];
      end else begin
         tx_byte = regs_reg[r_reg.idx][15:8];
         tx_first = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer.

   // One pass computes the next state and any register commit.
   always_comb begin
      r_next = r_reg;
      r_next.scl_prev = scl;
      r_next.sda_prev = sda;
      wr_en = 1'b0;
      wr_idx = r_reg.idx;
      wr_data = {r_reg.hi_byte, r_reg.shift};
      if (start_seen) begin
         r_next.st = tws_pkg::ST_ADDR;
         r_next.cnt = '0;
         r_next.half = 1'b0;
         r_next.drive_low = 1'b0;
      end else if (stop_seen) begin
         r_next.st = tws_pkg::ST_IDLE;
         r_next.drive_low = 1'b0;
      end else begin
         case (r_reg.st)
            tws_pkg::ST_IDLE: begin
               r_next.drive_low = 1'b0;
            end
            tws_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  r_next.shift = {r_reg.shift[6:0], sda};
                  r_next.cnt = r_reg.cnt + 4'h1;
               end else if (scl_fall && r_reg.cnt == tws_pkg::BITS_PER_BYTE) begin
                  if (r_reg.shift[7:1] == my_id[7:1]) begin
                     r_next.drive_low = 1'b1;
                     r_next.rd = r_reg.shift[0];
                     r_next.st = tws_pkg::ST_AACK;
                  end else begin
                     r_next.st = tws_pkg::ST_IGN;
                  end
               end
            end
            tws_pkg::ST_AACK: begin
               if (scl_fall) begin
                  r_next.cnt = '0;
                  if (r_reg.rd) begin
                     r_next.shift = tx_byte;
                     r_next.drive_low = !tx_byte[7];
                     r_next.st = tws_pkg::ST_TX;
                     if (tx_first) begin
                        r_next.hi_idx = r_reg.idx;
                     end
                  end else begin
                     r_next.drive_low = 1'b0;
                     r_next.need_idx = 1'b1;
                     r_next.st = tws_pkg::ST_RX;
                  end
               end
            end
            tws_pkg::ST_RX: begin
               if (scl_rise) begin
                  r_next.shift = {r_reg.shift[6:0], sda};
                  r_next.cnt = r_reg.cnt + 4'h1;
               end else if (scl_fall && r_reg.cnt == tws_pkg::BITS_PER_BYTE) begin
                  r_next.drive_low = 1'b1;
                  r_next.st = tws_pkg::ST_DACK;
                  if (r_reg.need_idx) begin
                     r_next.idx = r_reg.shift;
                     r_next.need_idx = 1'b0;
                     r_next.half = 1'b0;
                  end else if (r_reg.idx == tws_pkg::BYTE_LANE_IDX && !r_reg.half) begin
                     wr_en = 1'b1;
                     wr_idx = r_reg.hi_idx;
                  end else if (!r_reg.half) begin
                     r_next.hi_byte = r_reg.shift;
                     r_next.hi_idx = r_reg.idx;
                     r_next.half = 1'b1;
                  end else begin
                     wr_en = 1'b1;
                     r_next.idx = r_reg.idx + 8'h01;
                     r_next.half = 1'b0;
                  end
               end
            end
            tws_pkg::ST_DACK: begin
               if (scl_fall) begin
                  r_next.drive_low = 1'b0;
                  r_next.cnt = '0;
                  r_next.st = tws_pkg::ST_RX;
               end
            end
            tws_pkg::ST_TX: begin
               if (scl_rise) begin
                  r_next.cnt = r_reg.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (r_reg.cnt == tws_pkg::BITS_PER_BYTE) begin
                     r_next.drive_low = 1'b0;
                     r_next.st = tws_pkg::ST_MACK;
                     if (r_reg.idx != tws_pkg::BYTE_LANE_IDX) begin
                        if (r_reg.half) begin
                           r_next.idx = r_reg.idx + 8'h01;
                           r_next.half = 1'b0;
                        end else begin
                           r_next.half = 1'b1;
                        end
                     end
                  end else begin
                     r_next.shift = {r_reg.shift[6:0], 1'b1};
                     r_next.drive_low = !r_reg.shift[6];
                  end
               end
            end
            tws_pkg::ST_MACK: begin
               if (scl_rise) begin
                  r_next.nack = sda;
               end else if (scl_fall) begin
                  r_next.cnt = '0;
                  if (r_reg.nack) begin
                     r_next.st = tws_pkg::ST_IGN;
                  end else begin
                     r_next.shift = tx_byte;
                     r_next.drive_low = !tx_byte[7];
                     r_next.st = tws_pkg::ST_TX;
                     if (tx_first) begin
                        r_next.hi_idx = r_reg.idx;
                     end
                  end
               end
            end
            tws_pkg::ST_IGN: begin
               r_next.drive_low = 1'b0;
            end
            default: begin
               r_next.st = tws_pkg::ST_IDLE;
               r_next.drive_low = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Registers.

   // Sequencer state; the clock enable freezes everything.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r_reg.st <= tws_pkg::ST_IDLE;
         r_reg.scl_prev <= 1'b1;
         r_reg.sda_prev <= 1'b1;
         r_reg.shift <= tws_pkg::BYTE_RESET;
         r_reg.cnt <= '0;
         r_reg.drive_low <= 1'b0;
         r_reg.rd <= 1'b0;
         r_reg.need_idx <= 1'b0;
         r_reg.half <= 1'b0;
         r_reg.nack <= 1'b0;
         r_reg.idx <= tws_pkg::BYTE_RESET;
         r_reg.hi_byte <= tws_pkg::BYTE_RESET;
         r_reg.hi_idx <= tws_pkg::BYTE_RESET;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   // Register array; a word is written only as a whole.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 0; i < tws_pkg::REG_COUNT; i++) begin
            regs_reg[i] <= tws_pkg::REG_RESET;
         end
      end else if (ce && wr_en) begin
         regs_reg[wr_idx] <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin drive.

   // The line is only pulled low or released, never driven high.
   assign serial_data_line_out = 1'b0;
   assign serial_data_line_oe = r_reg.drive_low;

endmodule // tws_slave

// File: shared/tws_pkg.sv
/*
 * Constants shared by the two-wire register slave: bus identities,
 * register geometry, the byte-lane index and state codes.
 * Assumes a single master clock domain that samples the serial pins.
 */
package tws_pkg;

   // Write-direction bus identities selected by the two strap pins.
   localparam logic [7:0] ID_STRAP_00 = 8'h90;
   localparam logic [7:0] ID_STRAP_01 = 8'h98;
   localparam logic [7:0] ID_STRAP_10 = 8'hB0;
   localparam logic [7:0] ID_STRAP_11 = 8'hB8;

   // Register geometry.
   localparam int REG_WIDTH = 16;
   localparam int IDX_WIDTH = 8;
   localparam int REG_COUNT = 256;
   localparam int SYNC_WIDTH = 4;

   // Index of the byte-lane access register.
   localparam logic [7:0] BYTE_LANE_IDX = 8'hF0;

   // Reset values and the bit count per byte.
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Sequencer states, one-hot.
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ADDR = 8'h02,
      ST_AACK = 8'h04,
      ST_RX = 8'h08,
      ST_DACK = 8'h10,
      ST_TX = 8'h20,
      ST_MACK = 8'h40,
      ST_IGN = 8'h80
   } tws_state_e;

endpackage

// File: rtl/tws_sync.sv
/*
 * Two-flop synchroniser bank for the pins that arrive from outside
 * the master clock domain. Assumes the inputs are asynchronous levels.
 */
module tws_sync (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [tws_pkg::SYNC_WIDTH-1:0] async_in,
   output logic [tws_pkg::SYNC_WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [tws_pkg::SYNC_WIDTH-1:0] meta;
      logic [tws_pkg::SYNC_WIDTH-1:0] stable;
   } tws_sync_s;

   tws_sync_s s_reg;
   tws_sync_s s_next;

   // Each bit passes two flops; the first is read only by the second.
   genvar g;
   generate
      for (g = 0; g < tws_pkg::SYNC_WIDTH; g++) begin : g_bit
         always_comb begin
            s_next.meta[g] = async_in[g];
            s_next.stable[g] = s_reg.meta[g];
         end
      end
   endgenerate

   // Idle lines are high, so the bank resets to ones.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_reg <= '1;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign sync_out = s_reg.stable;

endmodule // tws_sync

// File: dv/tws_checker.sv
/* Assertion checker for the two-wire register slave.
   Bound to every tws_slave instance and sees only its ports. */
module tws_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic serial_clock_line,
   input wire logic serial_data_line_in,
   input wire logic serial_data_line_out,
   input wire logic serial_data_line_oe,
   input wire logic bus_id_strap_hi,
   input wire logic bus_id_strap_lo
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   // Start and stop as seen on the raw pins: data moves while clock stays high.
   sequence s_start;
      serial_clock_line && $past(serial_clock_line) && $fell(serial_data_line_in);
   endsequence
   sequence s_stop;
      serial_clock_line && $past(serial_clock_line) && $rose(serial_data_line_in);
   endsequence
   // Pin behaviour of the open-drain data driver.
   a_out_low: assert property (serial_data_line_out == 1'b0)
      else $error("Data output is not held low.");
   a_oe_after_reset: assert property ($rose(rst_n) |-> !serial_data_line_oe)
      else $error("Data driven right after reset.");
   a_oe_scl_low: assert property
      ($changed(serial_data_line_oe) |-> !$past(serial_clock_line, 2))
      else $error("Data drive changed outside the clock low phase.");
   a_start_quiet: assert property (s_start |-> !serial_data_line_oe [*8])
      else $error("Data driven right after a start.");
   a_stop_quiet: assert property (s_stop |-> !serial_data_line_oe [*8])
      else $error("Data driven right after a stop.");
   a_oe_stands: assert property ($rose(serial_data_line_oe) |-> serial_data_line_oe [*6])
      else $error("Data drive shorter than one bit.");
   a_oe_bounded: assert property
      ($rose(serial_data_line_oe) |-> ##[1:80] !serial_data_line_oe)
      else $error("Data drive held beyond one byte.");
   // The wire already reflects the slave's own pull, so the check looks one cycle ahead.
   a_idle_release: assert property
      ((serial_clock_line && serial_data_line_in) [*8] |=> !serial_data_line_oe)
      else $error("Data driven on an idle bus.");
   a_no_own_start: assert property
      (serial_clock_line && $past(serial_clock_line) |-> !$rose(serial_data_line_oe))
      else $error("Slave pulled data low while the clock was high.");
endmodule // tws_checker

bind tws_slave tws_checker u_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce),
   .serial_clock_line(serial_clock_line), .serial_data_line_in(serial_data_line_in),
   .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
   .bus_id_strap_hi(bus_id_strap_hi), .bus_id_strap_lo(bus_id_strap_lo));

// File: dv/tws_master.sv
/* Partner model: the two-wire bus master, driving the serial clock and
   pulling the data wire low. Assumes the bench models the pull-up. */
module tws_master (
   input wire logic mclk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////
   // Idle bus at time zero: clock high, data released.
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Waits a number of falling edges of the master clock.
   task automatic w(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // One 400 ns clock pulse; data moves only while the clock is low.
   task automatic pulse(input logic pull, output logic seen);
      scl = 1'b0;
      w(2);
      sda_low = pull;
      w(2);
      scl = 1'b1;
      w(3);
      seen = sda;
      w(1);
   endtask
   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      logic x;
      pulse(1'b0, x);
      sda_low = 1'b1;
      w(4);
   endtask
   // Stop: data rises while the clock is high.
   task automatic stop();
      logic x;
      pulse(1'b1, x);
      sda_low = 1'b0;
      w(8);
   endtask
   // Sends a byte, top bit first, then reads the acknowledge slot.
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) pulse(!d[i], s);
      pulse(1'b0, s);
      ack = !s;
   endtask
   // Receives a byte, then acknowledges it or refuses it to end the read.
   task automatic recv(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) pulse(1'b0, d[i]);
      pulse(more, s);
   endtask
endmodule // tws_master

// File: dv/testbench.sv
/* Self-checking bench for the two-wire register slave.
   Assumes the master model drives the bus and the wire has a pull-up. */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [1:0] strap; logic [7:0] id; logic ack;} tws_row_s;
   logic mclk, rst_n, ce, hi, lo, scl, m_low, oe, dout, a;
   logic [31:0] q;
   int err_total, samples_checked;
   tws_row_s rows [8];
   wire logic sda;
   ////////////////////////////////////////
   // Pull-up wire: low while either party pulls it.
   assign sda = ((oe && !dout) || m_low) ? 1'b0 : 1'b1;
   tws_slave dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .serial_clock_line(scl),
      .serial_data_line_in(sda), .serial_data_line_out(dout), .serial_data_line_oe(oe),
      .bus_id_strap_hi(hi), .bus_id_strap_lo(lo));
   tws_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));
   // 20 MHz master clock.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Compares and counts.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ok(input logic got);
      chk({31'h0, got}, 32'h1);
   endtask
   task automatic final_report();
      $display("Checks %0d, errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Writes n bytes from the top of d starting at register idx, then stops.
   task automatic wr(input logic [7:0] idx, input logic [31:0] d, input int n);
      m.start();
      m.send(8'h90, a);
      ok(a);
      m.send(idx, a);
      ok(a);
      for (int k = 0; k < n; k++) begin
         m.send(d[31-8*k -: 8], a);
         ok(a);
      end
      m.stop();
   endtask
   // Reads n bytes from register idx through a repeated start into q.
   task automatic rd(input logic [7:0] idx, input int n);
      logic [7:0] b;
      q = 32'h0;
      m.start();
      m.send(8'h90, a);
      ok(a);
      m.send(idx, a);
      ok(a);
      m.start();
      m.send(8'h91, a);
      ok(a);
      for (int k = 0; k < n; k++) begin
         m.recv(k < n - 1, b);
         q = {q[23:0], b};
      end
      m.stop();
   endtask
   // Main sequence: reset, address table, then word, byte and restart cases.
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      hi = 1'b0;
      lo = 1'b0;
      err_total = 0;
      samples_checked = 0;
      rows = '{{2'h0, 8'h90, 1'b1}, {2'h0, 8'h98, 1'b0}, {2'h1, 8'h98, 1'b1},
         {2'h1, 8'hB0, 1'b0}, {2'h2, 8'hB0, 1'b1}, {2'h2, 8'hB8, 1'b0},
         {2'h3, 8'hB8, 1'b1}, {2'h3, 8'h90, 1'b0}};
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      ce = 1'b0;
      m.w(4);
      ce = 1'b1;
      m.w(4);
      foreach (rows[i]) begin
         {hi, lo} = rows[i].strap;
         m.w(4);
         m.start();
         m.send(rows[i].id, a);
         chk({31'h0, a}, {31'h0, rows[i].ack});
         m.send(8'h09, a);
         chk({31'h0, a}, {31'h0, rows[i].ack});
         m.stop();
      end
      {hi, lo} = 2'h0;
      rd(8'h40, 2);
      chk(q, 32'h0);
      wr(8'h09, 32'h0284_1234, 4);
      rd(8'h09, 4);
      chk(q, 32'h0284_1234);
      wr(8'h0B, 32'hAA00_0000, 1);
      rd(8'h0B, 2);
      chk(q, 32'h0);
      wr(8'h0C, 32'h5600_0000, 1);
      wr(8'hF0, 32'h7800_0000, 1);
      rd(8'h0C, 2);
      chk(q, 32'h5678);
      rd(8'h09, 1);
      chk(q, 32'h02);
      rd(8'hF0, 1);
      chk(q, 32'h84);
      m.start();
      m.send(8'h90, a);
      m.send(8'h0D, a);
      repeat (3) m.pulse(1'b1, a);
      wr(8'h0D, 32'h1122_0000, 2);
      rd(8'h0D, 2);
      chk(q, 32'h1122);
      // Reset in mid-run on an idle bus clears the registers and the sequencer.
      rst_n = 1'b0;
      m.w(3);
      rst_n = 1'b1;
      m.w(4);
      rd(8'h0D, 2);
      chk(q, 32'h0);
      final_report();
   end
   // Watchdog: the sequence needs about 6300 cycles.
   initial begin
      repeat (60000) @(posedge mclk);
      err_total++;
      final_report();
   end
endmodule // testbench
